// file: smbs_pkg.sv
// Constants and types for the mode register and burst sequencer
package smbs_pkg;
  localparam int COL_W = 8;
  localparam int MODE_W = 12;
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W = 3;
  localparam int TEST_LSB = 7;
  localparam int TEST_W = 2;
  localparam int WBURST_BIT = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MODE_LOAD_NS = 100;
  localparam int MODE_LOAD_CYC = (MODE_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {SMBS_CMD_NOP, SMBS_CMD_MODE, SMBS_CMD_READ, SMBS_CMD_WRITE,
    SMBS_CMD_STOP, SMBS_CMD_OTHER} smbs_cmd_t;
endpackage

// file: smbs_col_if.sv
// Column-step signals between the sequencer and its address generator
`timescale 1ns/1ns
`default_nettype none
interface smbs_col_if;
  import smbs_pkg::*;
  logic [COL_W-1:0] start_col;
  logic [7:0] beat;
  logic [2:0] blen_code;
  logic interleave;
  logic [COL_W-1:0] col;
  modport seq (output start_col, output beat, output blen_code, output interleave, input col);
  modport gen (input start_col, input beat, input blen_code, input interleave, output col);
endinterface
`default_nettype wire

// file: smbs_col_gen.sv
// Burst column address generator
`timescale 1ns/1ns
`default_nettype none
module smbs_col_gen
  import smbs_pkg::*;
(
  smbs_col_if.gen cif // Start column and beat in, column out
);
  wire [COL_W-1:0] beat_c = cif.beat[COL_W-1:0];
  wire [COL_W-1:0] low_mask = (cif.blen_code == BL_2) ? 8'h01 :
                              (cif.blen_code == BL_4) ? 8'h03 :
                              (cif.blen_code == BL_8) ? 8'h07 :
                              (cif.blen_code == BL_PAGE) ? 8'hff : 8'h00;
  // Sequential: add within an aligned block; full page wraps 255 to 0
  wire [COL_W-1:0] seq_col = (cif.start_col & ~low_mask) |
                             ((cif.start_col + beat_c) & low_mask);
  wire [COL_W-1:0] ilv_col = (cif.start_col & ~low_mask) |
                             ((cif.start_col ^ beat_c) & low_mask);
  // Interleave with lengths other than 4 and 8 falls back to sequential
  wire ilv_ok = cif.interleave && (cif.blen_code == BL_4 || cif.blen_code == BL_8);
  assign cif.col = ilv_ok ? ilv_col : seq_col;
endmodule
`default_nettype wire

// file: smbs_top.sv
// Mode register and burst column sequencer of a two-bank SDRAM
`timescale 1ns/1ns
`default_nettype none
module smbs_top
  import smbs_pkg::*;
(
  input wire logic clk_sys_i, // Device clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic cs_n_i, // Chip select, active low
  input wire logic ras_n_i, // Row strobe, active low
  input wire logic cas_n_i, // Column strobe, active low
  input wire logic we_n_i, // Write enable, active low
  input wire logic [11:0] addr_i, // Address pins
  output logic [MODE_W-1:0] mode_o, // Stored mode register
  output logic [2:0] latency_o, // Read latency in clocks
  output logic nop_o, // No-operation registered this cycle
  output logic mode_busy_o, // Mode load still completing
  output logic burst_active_o, // Burst in progress
  output logic burst_write_o, // Burst is a write
  output logic [COL_W-1:0] col_o // Column of current beat
);
  smbs_col_if cif ();
  logic [MODE_W-1:0] burst_mode_config;
  logic [COL_W-1:0] start_col;
  logic [7:0] beat;
  logic active;
  logic is_write;
  logic [1:0] load_cnt;
  logic [COL_W-1:0] col_q;
  logic nop_q;

  wire selected = !cs_n_i;
  wire cmd_nop = selected && ras_n_i && cas_n_i && we_n_i;
  wire cmd_mode = selected && !ras_n_i && !cas_n_i && !we_n_i;
  wire cmd_rw = selected && ras_n_i && !cas_n_i;
  wire cmd_stop = selected && ras_n_i && cas_n_i && !we_n_i;
  wire [2:0] blen_code = burst_mode_config[BL_LSB +: BL_W];
  wire wr_single = burst_mode_config[WBURST_BIT];
  wire is_page = (blen_code == BL_PAGE);
  wire [7:0] blen_last = (blen_code == BL_2) ? 8'h01 :
                         (blen_code == BL_4) ? 8'h03 :
                         (blen_code == BL_8) ? 8'h07 : 8'h00;
  // Single-write mode collapses write bursts other than full page to one beat
  wire [7:0] last_beat = (is_write && wr_single) ? 8'h00 : blen_last;
  wire burst_done = active && !is_page && (beat == last_beat);
  // Burst-stop ends any burst; full page otherwise never ends
  wire next_active = cmd_rw ? 1'b1 : (cmd_stop || burst_done) ? 1'b0 : active;
  wire [7:0] next_beat = cmd_rw ? 8'h00 : (active ? beat + 8'h01 : beat);

  assign cif.start_col = cmd_rw ? addr_i[COL_W-1:0] : start_col;
  assign cif.beat = cmd_rw ? 8'h00 : next_beat;
  assign cif.blen_code = blen_code;
  assign cif.interleave = burst_mode_config[ORDER_BIT];

  smbs_col_gen u_col_gen (
    .cif(cif)
  );

  // Two-bit load counter bounds the completion window
  if (MODE_LOAD_CYC < 1 || MODE_LOAD_CYC > 3)
  begin : g_load_cnt_chk
    $error("mode load window does not fit the load counter");
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      burst_mode_config <= MODE_RESET;
    else if (cmd_mode)
      burst_mode_config <= {addr_i[11], 1'b0, addr_i[9:0]};
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      load_cnt <= 2'h0;
    else if (cmd_mode)
      load_cnt <= 2'(MODE_LOAD_CYC);
    else if (load_cnt != 2'h0)
      load_cnt <= load_cnt - 2'h1;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      active <= 1'b0;
      beat <= 8'h00;
      start_col <= 8'h00;
      is_write <= 1'b0;
      col_q <= 8'h00;
      nop_q <= 1'b0;
    end
    else
    begin
      active <= next_active;
      beat <= next_beat;
      if (cmd_rw)
      begin
        start_col <= addr_i[COL_W-1:0];
        is_write <= !we_n_i;
      end
      if (cmd_rw || (active && next_active))
        col_q <= cif.col;
      nop_q <= cmd_nop;
    end
  end

  // Reserved latency codes are not decoded; read path sees the raw field
  assign latency_o = burst_mode_config[LAT_LSB +: LAT_W];
  assign mode_o = burst_mode_config;
  assign nop_o = nop_q;
  assign mode_busy_o = (load_cnt != 2'h0);
  assign burst_active_o = active;
  assign burst_write_o = is_write;
  assign col_o = col_q;

  // Cycles with no command that would reshape a running burst
  sequence s_quiet;
    !cmd_rw && !cmd_stop && !cmd_mode;
  endsequence
  sequence s_rw1;
    cmd_rw && blen_code == BL_1;
  endsequence
  sequence s_rw2;
    cmd_rw && blen_code == BL_2 && (we_n_i || !wr_single);
  endsequence
  sequence s_rw4;
    cmd_rw && !is_page && blen_code == BL_4 && (we_n_i || !wr_single);
  endsequence
  sequence s_rw8;
    cmd_rw && blen_code == BL_8 && (we_n_i || !wr_single);
  endsequence

  a_mode_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_mode |=> burst_mode_config == {$past(addr_i[11]), 1'b0, $past(addr_i[9:0])})
    else $error("mode register not loaded from address");
  a_order_bit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_mode |=> cif.interleave == $past(addr_i[ORDER_BIT]))
    else $error("ordering bit not taken from address");
  a_lat_field: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_mode |=> latency_o == $past(addr_i[LAT_LSB +: LAT_W]))
    else $error("latency field not taken from address");
  a_nop_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_nop |=> nop_o)
    else $error("no-op not registered");
  a_busy_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_mode |=> mode_busy_o ##1 mode_busy_o)
    else $error("mode load window too short");
  a_start_col: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_rw |=> burst_active_o && col_o == $past(addr_i[COL_W-1:0]))
    else $error("first beat not at start column");
  a_write_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_rw |=> burst_write_o == !$past(we_n_i))
    else $error("burst direction not kept");
  a_burst_one: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_rw1 ##1 !cmd_rw |=> !burst_active_o)
    else $error("length one burst wrong duration");
  a_burst_two: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_rw2 ##1 s_quiet [*2] |=> !burst_active_o)
    else $error("length two burst wrong duration");
  a_burst_four: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_rw4 ##1 s_quiet [*4] |=> !burst_active_o)
    else $error("length four burst wrong duration");
  a_burst_eight: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_rw8 ##1 s_quiet [*8] |=> !burst_active_o)
    else $error("length eight burst wrong duration");
  a_single_wr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cmd_rw && !we_n_i && wr_single) ##1 !cmd_rw |=> !burst_active_o)
    else $error("single write burst lasted too long");
  a_read_bursts: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cmd_rw && we_n_i && wr_single && blen_code == BL_4) ##1 s_quiet |=> burst_active_o)
    else $error("read burst cut short in single write mode");
  a_seq_step: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (active && next_active && !cmd_rw && !cif.interleave && blen_code == BL_8)
    |=> col_o[2:0] == $past(col_o[2:0]) + 3'h1)
    else $error("sequential column step wrong");
  a_seq_four: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (active && next_active && !cmd_rw && !cif.interleave && blen_code == BL_4)
    |=> col_o[1:0] == $past(col_o[1:0]) + 2'h1 && col_o[7:2] == $past(col_o[7:2]))
    else $error("sequential length four step left its block");
  a_ilv_xor: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (active && next_active && !cmd_rw && cif.interleave && blen_code == BL_4)
    |=> col_o[1:0] == (start_col[1:0] ^ beat[1:0]))
    else $error("interleave column wrong");
  a_ilv_eight: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (active && next_active && !cmd_rw && cif.interleave && blen_code == BL_8)
    |=> col_o[2:0] == (start_col[2:0] ^ beat[2:0]))
    else $error("interleave length eight column wrong");
  a_page_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (active && next_active && !cmd_rw && is_page && col_o == 8'hff) |=> col_o == 8'h00)
    else $error("full page did not wrap");
  a_page_runs: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (active && is_page && !cmd_stop && !cmd_mode) |=> burst_active_o)
    else $error("full page burst ended by itself");
  a_stop_ends: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_stop |=> !burst_active_o)
    else $error("burst stop not obeyed");
endmodule
`default_nettype wire

// file: smbs_ctrl_model.sv
// Controller model driving command and address pins
`timescale 1ns/1ns
`default_nettype none
module smbs_ctrl_model
(
  input wire logic clk_i, // Device clock
  output logic [3:0] cmd_n_o, // Chip select, row, column, write strobes
  output logic [11:0] addr_o // Address pins
);
  initial
  begin
    cmd_n_o = 4'h7;
    addr_o = 12'h000;
  end
  // Pins change at the falling edge only; an idle address is scrambled
  task automatic issue(input logic [3:0] c, input logic [11:0] a);
    @(negedge clk_i);
    cmd_n_o <= c;
    addr_o <= (c == 4'h7) ? ~addr_o : a;
  endtask
  // Reserved, test and top bits forced low; only legal codes given
  task automatic load(input logic [11:0] m);
    issue(4'h0, m & 12'h27f);
  endtask
endmodule
`default_nettype wire

// file: smbs_tb.sv
// Self-checking bench for the mode register and burst sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, v); end end
module tb;
  import smbs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] cmd_n;
  logic [11:0] addr;
  logic [MODE_W-1:0] mode_o;
  logic [2:0] latency_o;
  logic nop_o, mode_busy_o, burst_active_o, burst_write_o;
  logic [COL_W-1:0] col_o;
  logic [8:0] q[$];
  logic [8:0] exp_beat;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h97641c16;
  smbs_ctrl_model m_u (.clk_i(clk_sys_i), .cmd_n_o(cmd_n), .addr_o(addr));
  smbs_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_n_i(cmd_n[3]),
    .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .addr_i(addr),
    .mode_o(mode_o), .latency_o(latency_o), .nop_o(nop_o), .mode_busy_o(mode_busy_o),
    .burst_active_o(burst_active_o), .burst_write_o(burst_write_o), .col_o(col_o));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // Every beat shown must match the oldest pending note
  always @(negedge clk_sys_i)
    if (burst_active_o === 1'b1)
    begin
      if (q.size() == 0)
        `CHK("spare beat", 1'b0, 1'b1)
      else
      begin
        exp_beat = q.pop_front();
        `CHK("beat", exp_beat, {burst_write_o, col_o})
      end
    end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic set_mode(input logic [11:0] m);
    m_u.load(m);
    m_u.issue(4'h7, 12'h000);
    `CHK("mode", m, mode_o)
    `CHK("latency", m[6:4], latency_o)
    `CHK("busy1", 1'b1, mode_busy_o)
    `CHK("nop0", 1'b0, nop_o)
    m_u.issue(4'h7, 12'h000);
    `CHK("busy2", 1'b1, mode_busy_o)
    m_u.issue(4'h7, 12'h000);
    `CHK("busy3", 1'b0, mode_busy_o)
    `CHK("nop", 1'b1, nop_o)
  endtask
  task automatic burst(input logic wr, input logic [7:0] s, input int n, input logic il);
    int i;
    for (i = 0; i < n; i++)
      q.push_back({wr, il ? (s ^ 8'(i)) : ((s & ~8'(n - 1)) | ((s + 8'(i)) & 8'(n - 1)))});
    m_u.issue(wr ? 4'h4 : 4'h5, {4'h0, s});
    for (i = 0; i < 20; i++)
    begin
      m_u.issue(4'h7, 12'h000);
      if (burst_active_o === 1'b0)
        break;
    end
    if (i == 20)
    begin
      fail_count++;
      test_done();
    end
    `CHK("drained", 0, q.size())
  endtask
  initial
  begin
    int c, il, i;
    int min_access_delay;
    logic wr, single;
    logic [7:0] s;
    logic [2:0] lat;
    lat = LAT_2;
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rstn_i = 1'b1;
    `CHK("reset mode", MODE_RESET, mode_o)
    for (c = 0; c < 4; c++)
      for (il = 0; il < 2; il++)
        if (il == 0 || c >= 2)
        begin
          wr = 1'($random(seed));
          single = 1'($random(seed));
          s = 8'($random(seed));
          // Access delay drawn so that both latency codes are reached
          min_access_delay = 40 + int'({$random(seed)} % 80);
          lat = (min_access_delay <= 2 * CLK_PERIOD_NS) ? LAT_2 : LAT_3;
          set_mode({2'h0, single, 2'h0, lat, il[0], c[2:0]});
          burst(wr, s, (wr && single) ? 1 : (1 << c), il[0]);
        end
    set_mode({5'h0, lat, 1'b0, BL_PAGE});
    for (i = 0; i < 11; i++)
      q.push_back({1'b0, 8'hfb + 8'(i)});
    m_u.issue(4'h5, 12'h0fb);
    repeat (10) m_u.issue(4'h7, 12'h000);
    m_u.issue(4'h6, 12'h000);
    m_u.issue(4'h7, 12'h000);
    `CHK("stopped", 1'b0, burst_active_o)
    `CHK("page drained", 0, q.size())
    test_done();
  end
endmodule
`default_nettype wire
